/* File: rtl/async_tx_dma.sv */
// Function
// - Descriptor command code 4'h1 identifies the end-of-packet descriptor.
// - Key field 3'h0 marks a buffer-referencing, non-immediate descriptor.
// - Ping flag 1 marks a round-trip timing packet; 0 means ordinary.
// - Ping time spans last bit sent until data received or gap.
// - Interrupt code 2'b11 always interrupts on completion.
// - Code 2'b01 interrupts unless ack was complete or pending.
// - Code 2'b00 never interrupts.
// - Request count gives bytes supplied starting at the buffer pointer.
// - Buffer pointer is the host address the bytes come from.
// - Next descriptor pointer is 28 bits; low four bits are zero.
// - Four-bit next count gives 16-byte blocks of next descriptor block.
// - Next count zero ends the list; otherwise only 2 to 8. The code starts a fetch for any nonzero count, 1 to 15.
// - Immediate descriptors count two blocks, buffer descriptors count one.
// - Channel control bits 15 to 0 are written back as result word.
// - Time tag is three seconds bits over thirteen cycle bits.
// - Request packets get their transmission time written to the tag.
// - Response packets leave this tag unused; the header holds it.
// - Descriptor is 16 bytes on a 16-byte boundary.
`timescale 1ns/100ps
`default_nettype none
module async_tx_dma (
  input  wire logic        core_clk_in,
  input  wire logic        nrst_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  output logic             mem_req_out,
  output logic             mem_we_out,
  output logic      [31:0] mem_addr_out,
  output logic      [31:0] mem_wdata_out,
  input  wire logic        mem_ack_in,
  input  wire logic [31:0] mem_rdata_in,
  output logic             fifo_valid_out,
  output logic      [7:0]  fifo_data_out,
  output logic             fifo_last_out,
  input  wire logic        fifo_ready_in,
  input  wire logic        response_ctx_in,
  input  wire logic        tx_last_bit_in,
  input  wire logic        rx_data_in,
  input  wire logic        subaction_gap_in,
  input  wire logic        ack_valid_in,
  input  wire logic [4:0]  ack_code_in,
  input  wire logic [2:0]  bus_seconds_count_in,
  input  wire logic [12:0] bus_cycle_number_in,
  output logic             done_irq_out
);
  async_tx_dma_pkg::dma_state_t state_q;

  logic        run_q;
  logic [31:0] cmd_ptr_q;
  logic [3:0]  z_q;
  logic [15:0] ccr_q;
  logic [31:0] desc0_q;
  logic [31:0] data_ptr_q;
  logic [31:0] branch_q;
  logic [15:0] time_in_q;
  logic [15:0] rem_q;
  logic [31:0] word_q;
  logic [1:0]  word_idx_q;
  logic [15:0] time_tag_q;
  logic [15:0] ping_cnt_q;
  logic        ping_run_q;
  logic [4:0]  ack_q;

  logic        apb_setup;
  logic        idle;
  logic [15:0] now_tag;
  logic [1:0]  int_ctl;
  logic        ping_pkt;
  logic [31:0] block_base;
  logic        byte_taken;
  logic [1:0]  next_lane;
  logic        apb_access;
  logic        cmd_ptr_wr;
  logic        start_pkt;
  logic        bad_desc;
  logic        bad_end;
  logic        ack_take;

  assign apb_setup  = psel_in && !penable_in;
  assign idle       = (state_q == async_tx_dma_pkg::ST_IDLE);
  assign now_tag    = {bus_seconds_count_in, bus_cycle_number_in};
  assign int_ctl    = desc0_q[async_tx_dma_pkg::INT_LSB +: 2];
  assign ping_pkt   = desc0_q[async_tx_dma_pkg::PING_BIT];
  // The end-of-packet descriptor is the final 16-byte block of its block,
  // whatever mix of immediate and buffer descriptors precedes it.
  assign block_base = {cmd_ptr_q[31:4], 4'h0} + ({28'h000_0000, z_q} - 32'h0000_0001) * async_tx_dma_pkg::BLOCK_BYTES;
  assign byte_taken = fifo_valid_out && fifo_ready_in;
  assign next_lane  = data_ptr_q[1:0] + 2'h1;
  // Registers change at the access edge, where the master sees pready high.
  assign apb_access = psel_in && penable_in && pready_out;
  assign cmd_ptr_wr = idle && apb_access && pwrite_in && paddr_in == async_tx_dma_pkg::COMMAND_PTR_OFS;
  assign start_pkt  = idle && !cmd_ptr_wr && run_q && z_q != 4'h0;
  assign bad_desc   = desc0_q[async_tx_dma_pkg::CMD_LSB +: 4] != async_tx_dma_pkg::CMD_LAST ||
                      desc0_q[async_tx_dma_pkg::KEY_LSB +: 3] != async_tx_dma_pkg::KEY_BUFFER;
  assign bad_end    = (state_q == async_tx_dma_pkg::ST_FETCH) && mem_ack_in &&
                      word_idx_q == async_tx_dma_pkg::STATUS_WORD && bad_desc;
  assign ack_take   = (state_q == async_tx_dma_pkg::ST_WAIT) && ack_valid_in && !ping_run_q;

  // Bus slave: answers in the first access cycle, no wait states.
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
    end else begin
      pready_out  <= apb_setup;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
      if (apb_setup) begin
        case (paddr_in)
          async_tx_dma_pkg::CONTROL_OFS:     prdata_out <= {31'h0000_0000, run_q};
          async_tx_dma_pkg::COMMAND_PTR_OFS: prdata_out <= {cmd_ptr_q[31:4], z_q};
          async_tx_dma_pkg::CHANNEL_CTL_OFS: prdata_out <= {16'h0000, ccr_q};
          async_tx_dma_pkg::TIME_TAG_OFS:    prdata_out <= {16'h0000, time_tag_q};
          default:                           pslverr_out <= 1'b1;
        endcase
      end
    end
  end

  // Run bit; clearing it lets the current packet finish, then stops.
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      run_q <= 1'b0;
    end else if (apb_access && pwrite_in && paddr_in == async_tx_dma_pkg::CONTROL_OFS) begin
      run_q <= pwdata_in[0];
    end
  end

  // Ping timer counts core clocks from the last transmitted bit until
  // the first received data or a subaction gap, saturating at full scale.
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ping_run_q <= 1'b0;
      ping_cnt_q <= 16'h0000;
    end else if (state_q != async_tx_dma_pkg::ST_WAIT) begin
      ping_run_q <= 1'b0;
      ping_cnt_q <= 16'h0000;
    end else if (tx_last_bit_in && ping_pkt) begin
      ping_run_q <= 1'b1;
      ping_cnt_q <= 16'h0000;
    end else if (ping_run_q) begin
      if (rx_data_in || subaction_gap_in) begin
        ping_run_q <= 1'b0;
      end else if (ping_cnt_q != async_tx_dma_pkg::PING_MAX) begin
        ping_cnt_q <= ping_cnt_q + 16'h0001;
      end
    end
  end

  // Completion interrupt, one pulse two cycles after the write-back is acknowledged.
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      done_irq_out <= 1'b0;
    end else if (state_q == async_tx_dma_pkg::ST_ADVANCE) begin
      case (int_ctl)
        async_tx_dma_pkg::INT_ALWAYS:   done_irq_out <= 1'b1;
        async_tx_dma_pkg::INT_ON_ERROR: done_irq_out <= (ack_q != async_tx_dma_pkg::ACK_COMPLETE) &&
                                                        (ack_q != async_tx_dma_pkg::ACK_PENDING);
        default:                        done_irq_out <= 1'b0;
      endcase
    end else begin
      done_irq_out <= 1'b0;
    end
  end

  // Command pointer: software loads it only while idle; a write in the idle cycle between
  // packets of a running list wins over the next fetch and redirects the list; each written-back packet reloads it from its branch word.
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cmd_ptr_q <= 32'h0000_0000;
      z_q       <= 4'h0;
    end else if (cmd_ptr_wr) begin
      cmd_ptr_q <= {pwdata_in[31:4], 4'h0};
      z_q       <= pwdata_in[3:0];
    end else if (state_q == async_tx_dma_pkg::ST_ADVANCE) begin
      cmd_ptr_q <= {branch_q[31:4], 4'h0};
      z_q       <= branch_q[3:0];
    end else if (bad_end) begin
      z_q <= 4'h0;
    end
  end

  // Channel control: run mirror, active and dead flags, last ack or event.
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ccr_q <= async_tx_dma_pkg::CCR_RESET;
    end else begin
      ccr_q[async_tx_dma_pkg::CCR_RUN] <= run_q;
      if (start_pkt) begin
        ccr_q[async_tx_dma_pkg::CCR_ACTIVE] <= 1'b1;
        ccr_q[async_tx_dma_pkg::CCR_DEAD]   <= 1'b0;
      end else if (bad_end) begin
        ccr_q[async_tx_dma_pkg::CCR_DEAD]   <= 1'b1;
        ccr_q[async_tx_dma_pkg::CCR_ACTIVE] <= 1'b0;
        ccr_q[4:0]                          <= async_tx_dma_pkg::EVT_BAD_DESC;
      end else if (idle) begin
        ccr_q[async_tx_dma_pkg::CCR_ACTIVE] <= 1'b0;
      end
      if (ack_take) begin
        ccr_q[4:0] <= ack_code_in;
      end
    end
  end

  // Time tag: the request stamp is caught at the last bit; a ping count or
  // the fetched response stamp replaces it when the ack is taken.
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      time_tag_q <= 16'h0000;
    end else begin
      if (state_q == async_tx_dma_pkg::ST_WAIT && tx_last_bit_in && !response_ctx_in && !ping_pkt) begin
        time_tag_q <= now_tag;
      end
      if (ack_take && ping_pkt) begin
        time_tag_q <= ping_cnt_q;
      end else if (ack_take && response_ctx_in) begin
        time_tag_q <= time_in_q;
      end
    end
  end

  // Descriptor engine: fetch, move bytes, wait for ack, write back, branch.
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q        <= async_tx_dma_pkg::ST_IDLE;
      desc0_q        <= 32'h0000_0000;
      data_ptr_q     <= 32'h0000_0000;
      branch_q       <= 32'h0000_0000;
      time_in_q      <= 16'h0000;
      rem_q          <= 16'h0000;
      word_q         <= 32'h0000_0000;
      word_idx_q     <= 2'h0;
      ack_q          <= 5'h00;
      mem_req_out    <= 1'b0;
      mem_we_out     <= 1'b0;
      mem_addr_out   <= 32'h0000_0000;
      mem_wdata_out  <= 32'h0000_0000;
      fifo_valid_out <= 1'b0;
      fifo_data_out  <= 8'h00;
      fifo_last_out  <= 1'b0;
    end else begin
      case (state_q)
        async_tx_dma_pkg::ST_IDLE: begin
          if (start_pkt) begin
            word_idx_q   <= 2'h0;
            mem_req_out  <= 1'b1;
            mem_we_out   <= 1'b0;
            mem_addr_out <= block_base;
            state_q      <= async_tx_dma_pkg::ST_FETCH;
          end
        end
        async_tx_dma_pkg::ST_FETCH: begin
          if (mem_ack_in) begin
            case (word_idx_q)
              2'h0:    desc0_q    <= mem_rdata_in;
              2'h1:    data_ptr_q <= mem_rdata_in;
              2'h2:    branch_q   <= mem_rdata_in;
              default: time_in_q  <= mem_rdata_in[15:0];
            endcase
            word_idx_q   <= word_idx_q + 2'h1;
            mem_addr_out <= mem_addr_out + 32'h0000_0004;
            if (word_idx_q == async_tx_dma_pkg::STATUS_WORD) begin
              mem_req_out <= 1'b0;
              if (bad_desc) begin
                state_q <= async_tx_dma_pkg::ST_IDLE;
              end else if (desc0_q[15:0] == 16'h0000) begin
                state_q <= async_tx_dma_pkg::ST_WAIT;
              end else begin
                rem_q        <= desc0_q[15:0];
                mem_req_out  <= 1'b1;
                mem_addr_out <= {data_ptr_q[31:2], 2'h0};
                state_q      <= async_tx_dma_pkg::ST_MOVE_RD;
              end
            end
          end
        end
        async_tx_dma_pkg::ST_MOVE_RD: begin
          if (mem_ack_in) begin
            mem_req_out    <= 1'b0;
            word_q         <= mem_rdata_in;
            fifo_data_out  <= mem_rdata_in[8 * data_ptr_q[1:0] +: 8];
            fifo_last_out  <= (rem_q == 16'h0001);
            fifo_valid_out <= 1'b1;
            state_q        <= async_tx_dma_pkg::ST_MOVE_TX;
          end
        end
        async_tx_dma_pkg::ST_MOVE_TX: begin
          if (byte_taken) begin
            rem_q      <= rem_q - 16'h0001;
            data_ptr_q <= data_ptr_q + 32'h0000_0001;
            if (rem_q == 16'h0001) begin
              fifo_valid_out <= 1'b0;
              fifo_last_out  <= 1'b0;
              state_q        <= async_tx_dma_pkg::ST_WAIT;
            end else if (data_ptr_q[1:0] == async_tx_dma_pkg::LAST_BYTE_LN) begin
              fifo_valid_out <= 1'b0;
              mem_req_out    <= 1'b1;
              mem_addr_out   <= {data_ptr_q[31:2], 2'h0} + 32'h0000_0004;
              state_q        <= async_tx_dma_pkg::ST_MOVE_RD;
            end else begin
              fifo_data_out <= word_q[8 * next_lane +: 8];
              fifo_last_out <= (rem_q == 16'h0002);
            end
          end
        end
        async_tx_dma_pkg::ST_WAIT: begin
          if (ack_take) begin
            ack_q   <= ack_code_in;
            state_q <= async_tx_dma_pkg::ST_WRITE;
          end
        end
        async_tx_dma_pkg::ST_WRITE: begin
          if (!mem_req_out) begin
            mem_req_out   <= 1'b1;
            mem_we_out    <= 1'b1;
            mem_addr_out  <= block_base + 32'h0000_000C;
            mem_wdata_out <= {ccr_q, time_tag_q};
          end else if (mem_ack_in) begin
            mem_req_out <= 1'b0;
            mem_we_out  <= 1'b0;
            state_q     <= async_tx_dma_pkg::ST_ADVANCE;
          end
        end
        async_tx_dma_pkg::ST_ADVANCE: begin
          state_q <= async_tx_dma_pkg::ST_IDLE;
        end
        default: begin
          state_q <= async_tx_dma_pkg::ST_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: shared/async_tx_dma_pkg.sv */
package async_tx_dma_pkg;
  // Register byte offsets on the bus.
  localparam logic [7:0] CONTROL_OFS     = 8'h00;
  localparam logic [7:0] COMMAND_PTR_OFS = 8'h04;
  localparam logic [7:0] CHANNEL_CTL_OFS = 8'h08;
  localparam logic [7:0] TIME_TAG_OFS    = 8'h0C;

  // Descriptor word 0 field positions.
  localparam int CMD_LSB  = 28;
  localparam int KEY_LSB  = 24;
  localparam int PING_BIT = 23;
  localparam int INT_LSB  = 20;
  localparam int BR_LSB   = 18;

  localparam logic [3:0] CMD_LAST     = 4'h1;
  localparam logic [2:0] KEY_BUFFER   = 3'h0;
  localparam logic [1:0] INT_ALWAYS   = 2'b11;
  localparam logic [1:0] INT_ON_ERROR = 2'b01;
  localparam logic [1:0] INT_NEVER    = 2'b00;
  localparam logic [1:0] BR_ALWAYS    = 2'b11;

  localparam logic [4:0] ACK_COMPLETE = 5'h11;
  localparam logic [4:0] ACK_PENDING  = 5'h12;
  localparam logic [4:0] EVT_BAD_DESC = 5'h05;

  // Descriptor geometry: 16-byte blocks, status word offset in a block, last byte lane in a word.
  localparam logic [31:0] BLOCK_BYTES   = 32'h0000_0010;
  localparam logic [1:0]  STATUS_WORD   = 2'h3;
  localparam logic [1:0]  LAST_BYTE_LN  = 2'h3;

  // Channel control register bit positions.
  localparam int CCR_RUN    = 15;
  localparam int CCR_DEAD   = 11;
  localparam int CCR_ACTIVE = 10;

  localparam logic [15:0] CCR_RESET   = 16'h0000;
  localparam logic [15:0] PING_MAX    = 16'hFFFF;

  typedef enum logic [6:0] {
    ST_IDLE    = 7'b000_0001,
    ST_FETCH   = 7'b000_0010,
    ST_MOVE_RD = 7'b000_0100,
    ST_MOVE_TX = 7'b000_1000,
    ST_WAIT    = 7'b001_0000,
    ST_WRITE   = 7'b010_0000,
    ST_ADVANCE = 7'b100_0000
  } dma_state_t;
endpackage

/* File: testbench/async_tx_dma_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module async_tx_dma_asserts (
  input wire logic        core_clk_in,
  input wire logic        nrst_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic        mem_req_out,
  input wire logic        mem_we_out,
  input wire logic [31:0] mem_addr_out,
  input wire logic        mem_ack_in,
  input wire logic        fifo_valid_out,
  input wire logic [7:0]  fifo_data_out,
  input wire logic        fifo_last_out,
  input wire logic        fifo_ready_in,
  input wire logic        done_irq_out
);
  wire logic wr_done = mem_req_out & mem_we_out & mem_ack_in;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  property p_ready; psel_in && !penable_in |=> pready_out && !$past(pready_out); endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  property p_err; pslverr_out |-> pready_out; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_hold; mem_req_out && !mem_ack_in |=> mem_req_out && $stable(mem_addr_out) && $stable(mem_we_out); endproperty
  a_hold: assert property (p_hold) else $error("memory request dropped");
  property p_align; mem_req_out |-> mem_addr_out[1:0] == 2'b00; endproperty
  a_align: assert property (p_align) else $error("unaligned access");
  property p_slot; mem_req_out && mem_we_out |-> mem_addr_out[3:0] == 4'hC; endproperty
  a_slot: assert property (p_slot) else $error("write outside status word");
  property p_byte; fifo_valid_out && !fifo_ready_in |=> fifo_valid_out && $stable(fifo_data_out); endproperty
  a_byte: assert property (p_byte) else $error("byte not held");
  property p_close; fifo_valid_out && fifo_last_out && fifo_ready_in |=> !fifo_valid_out [*4]; endproperty
  a_close: assert property (p_close) else $error("bytes after packet end");
  property p_order; fifo_valid_out |-> !(mem_req_out && mem_we_out); endproperty
  a_order: assert property (p_order) else $error("write-back before close");
  property p_irq; done_irq_out |-> $past(wr_done) || $past(wr_done, 2); endproperty
  a_irq: assert property (p_irq) else $error("interrupt without completion");
endmodule
`default_nettype wire

/* File: testbench/host_mem_model.sv */
`timescale 1ns/100ps
`default_nettype none
module host_mem_model (
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  input  wire logic        req_in,
  input  wire logic        we_in,
  input  wire logic [31:0] addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic [1:0]  lag_in,
  output logic             ack_out,
  output logic      [31:0] rdata_out
);
  logic [31:0] mem [64];
  logic [1:0]  wait_q;
  // Read data inverts between answers so stale data never passes for good data.
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ack_out <= 1'b0;
      wait_q <= 2'h0;
      rdata_out <= 32'h0000_0000;
    end else if (req_in && !ack_out && wait_q == lag_in) begin
      ack_out <= 1'b1;
      wait_q <= 2'h0;
      rdata_out <= mem[addr_in[7:2]];
      if (we_in) mem[addr_in[7:2]] <= wdata_in;
    end else begin
      ack_out <= 1'b0;
      wait_q <= (req_in && !ack_out) ? wait_q + 2'h1 : 2'h0;
      rdata_out <= ~rdata_out;
    end
  end
endmodule
`default_nettype wire

/* File: testbench/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        core_clk_in, nrst_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out, mem_req_out;
  logic        mem_we_out, mem_ack_in, fifo_valid_out, fifo_last_out, fifo_ready_in, response_ctx_in;
  logic        tx_last_bit_in, rx_data_in, subaction_gap_in, ack_valid_in, done_irq_out, err;
  logic [7:0]  paddr_in, fifo_data_out;
  logic [31:0] pwdata_in, prdata_out, mem_addr_out, mem_wdata_out, mem_rdata_in, rd;
  logic [4:0]  ack_code_in;
  logic [2:0]  bus_seconds_count_in;
  logic [12:0] bus_cycle_number_in;
  logic [1:0]  lag;
  int          n_errors, total_checks, cyc, irqs;

  async_tx_dma u_dut (.*);
  host_mem_model u_mem (.clk_in(core_clk_in), .nrst_in(nrst_in), .req_in(mem_req_out), .we_in(mem_we_out),
    .addr_in(mem_addr_out), .wdata_in(mem_wdata_out), .lag_in(lag), .ack_out(mem_ack_in), .rdata_out(mem_rdata_in));

  initial begin
    core_clk_in = 1'b0;
    forever #25 core_clk_in = ~core_clk_in;
  end

  always @(posedge core_clk_in) begin
    {bus_seconds_count_in, bus_cycle_number_in} <= {bus_seconds_count_in, bus_cycle_number_in} + 16'h0001;
    irqs <= irqs + int'(done_irq_out === 1'b1);
    cyc <= cyc + 1;
    // The run needs several hundred cycles, so this only trips on a hang.
    if (cyc == 30000) begin
      n_errors++;
      finish_test();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_in);
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} <= {2'b10, wr, a, d};
    tick(1);
    penable_in <= 1'b1;
    do tick(1); while (pready_out !== 1'b1);
    rd = prdata_out;
    err = pslverr_out;
    {psel_in, penable_in} <= 2'b00;
    tick(1);
  endtask

  task automatic put_desc(input logic [7:0] at, input logic [3:0] cmd, input logic p, input logic [1:0] ic,
                          input logic [15:0] n, input logic [31:0] nxt);
    u_mem.mem[at[7:2]] = {cmd, 4'h0, p, 1'b0, ic, 2'b11, 2'h0, n};
    u_mem.mem[at[7:2] + 6'h1] = 32'h0000_0082;
    u_mem.mem[at[7:2] + 6'h2] = nxt;
    u_mem.mem[at[7:2] + 6'h3] = 32'h0000_5A5A;
  endtask

  task automatic start();
    apb(1'b1, async_tx_dma_pkg::COMMAND_PTR_OFS, 32'h0000_0002);
    apb(1'b1, async_tx_dma_pkg::CONTROL_OFS, 32'h0000_0001);
  endtask

  task automatic run_pkt(input logic [7:0] at, input int n, input logic [4:0] ak, input logic [1:0] m,
                         input logic ex);
    logic [31:0] w;
    logic [15:0] t;
    int          k, c, b;
    k = 0;
    c = 0;
    b = irqs;
    while (k < n) begin
      tick(1);
      if (fifo_valid_out === 1'b1 && fifo_ready_in === 1'b1) begin
        w = u_mem.mem[(130 + k) / 4] >> (8 * ((130 + k) % 4));
        check(fifo_data_out, w[7:0]);
        check(fifo_last_out, k == n - 1);
        k++;
      end
      c++;
      fifo_ready_in <= c % 3 != 0;
    end
    tick(2);
    check(fifo_valid_out, 1'b0);
    tx_last_bit_in <= 1'b1;
    tick(1);
    t = {bus_seconds_count_in, bus_cycle_number_in};
    tx_last_bit_in <= 1'b0;
    if (m[0]) begin
      tick(4);
      {rx_data_in, subaction_gap_in} <= m[1] ? 2'b01 : 2'b10;
      tick(1);
      {rx_data_in, subaction_gap_in} <= 2'b00;
    end
    {ack_valid_in, ack_code_in} <= {1'b1, ak};
    tick(1);
    ack_valid_in <= 1'b0;
    while ((mem_req_out & mem_we_out & mem_ack_in) !== 1'b1) tick(1);
    check(mem_addr_out, at + 8'hC);
    w = mem_wdata_out;
    check({w[31], w[27], w[20:16]}, {2'b10, ak});
    if (m[0]) check(w[15:0] > 3 && w[15:0] < 7, 1'b1);
    else check(w[15:0], m[1] ? 16'h5A5A : t);
    tick(4);
    check(irqs - b, ex);
    $display("packet at %h done", at);
  endtask

  task automatic t_irq();
    logic [1:0] ic [5] = '{2'b11, 2'b01, 2'b01, 2'b01, 2'b00};
    logic [4:0] ak [5] = '{5'h1B, 5'h11, 5'h12, 5'h1B, 5'h1B};
    logic       ex [5] = '{1, 0, 0, 1, 0};
    for (int i = 0; i < 5; i++) begin
      lag <= i[1:0];
      put_desc(8'h10, 4'h1, 1'b0, ic[i], 16'(i + 1), 32'h0);
      start();
      run_pkt(8'h10, i + 1, ak[i], 2'd0, ex[i]);
    end
    $display("test irq done");
  endtask

  task automatic t_time();
    for (int m = 1; m < 4; m++) begin
      response_ctx_in <= m == 2;
      put_desc(8'h10, 4'h1, m[0], 2'b00, 16'h0003, 32'h0);
      start();
      run_pkt(8'h10, 3, 5'h11, m[1:0], 1'b0);
    end
    response_ctx_in <= 1'b0;
    $display("test time done");
  endtask

  task automatic t_chain();
    put_desc(8'h10, 4'h1, 1'b0, 2'b11, 16'h0004, 32'h0000_0032);
    put_desc(8'h40, 4'h1, 1'b0, 2'b11, 16'h0005, 32'h0);
    start();
    run_pkt(8'h10, 4, 5'h11, 2'd0, 1'b1);
    run_pkt(8'h40, 5, 5'h11, 2'd0, 1'b1);
    $display("test chain done");
  endtask

  task automatic t_bad();
    apb(1'b1, 8'h10, 32'hFFFF_FFFF);
    check(err, 1'b1);
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, async_tx_dma_pkg::CONTROL_OFS, 32'h0);
      put_desc(8'h10, 4'(i), 1'b0, 2'b11, 16'h0002, 32'h0);
      u_mem.mem[4] = u_mem.mem[4] | {5'h0, i[0], 26'h0};
      start();
      tick(40);
      check(fifo_valid_out, 1'b0);
      apb(1'b0, async_tx_dma_pkg::CHANNEL_CTL_OFS, 32'h0);
      check({rd[11], rd[4:0]}, 6'h25);
    end
    $display("test bad done");
  endtask

  initial begin
    {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in, fifo_ready_in, response_ctx_in} = '0;
    {tx_last_bit_in, rx_data_in, subaction_gap_in, ack_valid_in, ack_code_in, lag} = '0;
    {bus_seconds_count_in, bus_cycle_number_in} = 16'hFF00;
    {n_errors, total_checks, cyc, irqs} = '0;
    for (int i = 0; i < 64; i++) u_mem.mem[i] = 32'h1357_9BDF * (i + 1);
    nrst_in = 1'b0;
    tick(12);
    nrst_in <= 1'b1;
    tick(1);
    apb(1'b0, async_tx_dma_pkg::CHANNEL_CTL_OFS, 32'h0);
    check(rd[15:0], async_tx_dma_pkg::CCR_RESET);
    t_irq();
    t_time();
    t_chain();
    t_bad();
    finish_test();
  end
endmodule

bind async_tx_dma async_tx_dma_asserts u_chk (.*);
`default_nettype wire
